// ### rtl/bru_defines.svh
// Constants for the byte rotate instruction unit
`ifndef BRU_DEFINES_SVH
`define BRU_DEFINES_SVH

`define BRU_AW 13
`define BRU_MEM_AW 12
// Register port offsets, bit 12 set selects the data memory window
`define BRU_MEM_SEL 12
`define BRU_REG_CTRL 13'h0000
`define BRU_REG_INSTR 13'h0001
`define BRU_REG_WREG 13'h0002
`define BRU_REG_STATUS 13'h0003
`define BRU_REG_BANK 13'h0004
`define BRU_REG_INDEX 13'h0005
`define BRU_REG_STATE 13'h0006
// Field positions
`define BRU_CTRL_EXT 0
`define BRU_ST_C 0
`define BRU_ST_Z 1
`define BRU_ST_N 2
`define BRU_STATE_BUSY 0
`define BRU_D_BIT 9
`define BRU_A_BIT 8
// Opcode top six bits
`define BRU_OPC_RLNC 6'h11
`define BRU_OPC_ROTATE_RIGHT_VIA_CARRY_OP 6'h0C
`define BRU_OPC_ROTATE_LEFT_VIA_CARRY_OP 6'h0D
// Addressing
`define BRU_ACC_SPLIT 8'h5F
`define BRU_LOW_BANK 4'h0
`define BRU_SFR_BANK 4'hF
// Clock cycles per quarter phase
`define BRU_QDIV 2'h2
`define BRU_QDIV_LAST 2'h1

`endif

// ### rtl/bru_pkg.sv
// Types shared by the byte rotate instruction unit
package bru_pkg;
    typedef enum logic [1:0] {OP_NONE, OP_RLNC, OP_ROTATE_RIGHT_VIA_CARRY_OP, OP_ROTATE_LEFT_VIA_CARRY_OP} bru_op_type;
    typedef enum logic [2:0] {ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4} bru_state_type;
endpackage : bru_pkg

// ### rtl/bru_if.sv
// Link between the sequencer and the rotate datapath
`timescale 1ns/1ps
`default_nettype none
interface bru_if;
    import bru_pkg::*;
    bru_op_type op;
    logic [7:0] opnd;
    logic c_in;
    logic [7:0] res;
    logic c_out;
    logic n;
    logic z;
    modport core (output op, output opnd, output c_in, input res, input c_out, input n, input z);
    modport alu (input op, input opnd, input c_in, output res, output c_out, output n, output z);
endinterface : bru_if
`default_nettype wire

// ### rtl/bru_alu.sv
// Combinational rotate datapath
`timescale 1ns/1ps
`default_nettype none
module bru_alu
    import bru_pkg::*;
(
    bru_if.alu dp // Operands in, result and flags out
);
    always_comb begin
        dp.res = dp.opnd;
        dp.c_out = dp.c_in;
        case (dp.op)
            OP_RLNC: begin
                dp.res = {dp.opnd[6:0], dp.opnd[7]};
            end
            OP_ROTATE_RIGHT_VIA_CARRY_OP: begin
                dp.res = {dp.c_in, dp.opnd[7:1]};
                dp.c_out = dp.opnd[0];
            end
            OP_ROTATE_LEFT_VIA_CARRY_OP: begin
                dp.res = {dp.opnd[6:0], dp.c_in};
                dp.c_out = dp.opnd[7];
            end
            default: begin
                dp.res = dp.opnd;
            end
        endcase
        dp.n = dp.res[7];
        dp.z = (dp.res == 8'h00);
    end
endmodule : bru_alu
`default_nettype wire

// ### rtl/bru_top.sv
// Byte rotate instruction unit: sequencer, registers and file memory
//
// The plain strobed port and the register addresses were decided locally.
`include "bru_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module bru_top
    import bru_pkg::*;
(
    input wire logic clk_i, // 40 MHz core clock
    input wire logic rst_n_i, // Synchronous reset, active low
    input wire logic [`BRU_AW-1:0] addr_i, // Register port address
    input wire logic [15:0] wr_data_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [15:0] rd_data_o, // Read data, one cycle after strobe
    output logic busy_o // Instruction in progress
);
    ////////////////////////////////////////////////////////////////
    function automatic logic [`BRU_MEM_AW-1:0] eff_addr(input logic [7:0] f, input logic a,
            input logic [3:0] bank, input logic ext, input logic [11:0] idx);
        logic [`BRU_MEM_AW-1:0] r;
        r = {bank, f};
        if (!a) begin
            if (ext && f <= `BRU_ACC_SPLIT) begin
                r = idx + {4'h0, f};
            end else if (f <= `BRU_ACC_SPLIT) begin
                r = {`BRU_LOW_BANK, f};
            end else begin
                r = {`BRU_SFR_BANK, f};
            end
        end
        return r;
    endfunction : eff_addr

    logic [7:0] mem_q [0:(1 << `BRU_MEM_AW)-1];
    logic [1:0] div_q;
    logic q_en_q;
    bru_state_type state_q;
    bru_op_type op_q;
    logic [15:0] instr_q;
    logic pend_q;
    logic busy_q;
    logic ext_q;
    logic [7:0] wreg_q;
    logic c_q, z_q, n_q;
    logic [3:0] bank_q;
    logic [11:0] idx_q;
    logic [`BRU_MEM_AW-1:0] ea_q;
    logic [7:0] opnd_q;
    logic [7:0] res_q;
    logic c_new_q, z_new_q, n_new_q;
    logic dst_q;
    logic [15:0] rd_data_q;
    logic sw_wr_reg, sw_wr_mem, commit;
    bru_if dp ();

    assign sw_wr_reg = wr_i && !addr_i[`BRU_MEM_SEL];
    assign sw_wr_mem = wr_i && addr_i[`BRU_MEM_SEL];
    assign commit = (state_q == ST_Q4) && q_en_q;
    assign dp.op = op_q;
    assign dp.opnd = opnd_q;
    assign dp.c_in = c_q;

    bru_alu u_alu (
        .dp(dp)
    );

    ////////////////////////////////////////////////////////////////
    // Quarter phase divider
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_q <= 2'h0;
            q_en_q <= 1'b0;
        end else begin
            q_en_q <= (div_q == `BRU_QDIV_LAST);
            div_q <= (div_q == `BRU_QDIV_LAST) ? 2'h0 : div_q + 2'h1;
        end
    end

    // Instruction launch; writes while busy are dropped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            instr_q <= 16'h0000;
            pend_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (sw_wr_reg && addr_i == `BRU_REG_INSTR && !busy_q) begin
                instr_q <= wr_data_i;
                pend_q <= 1'b1;
                busy_q <= 1'b1;
            end else begin
                if (state_q == ST_IDLE && q_en_q) begin
                    pend_q <= 1'b0;
                end
                if (commit) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Quarter sequencer: decode, read, process, write
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
        end else if (q_en_q) begin
            case (state_q)
                ST_IDLE: state_q <= pend_q ? ST_Q1 : ST_IDLE;
                ST_Q1: state_q <= ST_Q2;
                ST_Q2: state_q <= ST_Q3;
                ST_Q3: state_q <= ST_Q4;
                ST_Q4: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Q1 decode
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            op_q <= OP_NONE;
            dst_q <= 1'b0;
            ea_q <= 12'h000;
        end else if (state_q == ST_Q1 && q_en_q) begin
            case (instr_q[15:10])
                `BRU_OPC_RLNC: op_q <= OP_RLNC;
                `BRU_OPC_ROTATE_RIGHT_VIA_CARRY_OP: op_q <= OP_ROTATE_RIGHT_VIA_CARRY_OP;
                `BRU_OPC_ROTATE_LEFT_VIA_CARRY_OP: op_q <= OP_ROTATE_LEFT_VIA_CARRY_OP;
                default: op_q <= OP_NONE;
            endcase
            dst_q <= instr_q[`BRU_D_BIT];
            ea_q <= eff_addr(instr_q[7:0], instr_q[`BRU_A_BIT], bank_q, ext_q, idx_q);
        end
    end

    // Q2 operand read, Q3 process
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            opnd_q <= 8'h00;
            res_q <= 8'h00;
            c_new_q <= 1'b0;
            z_new_q <= 1'b0;
            n_new_q <= 1'b0;
        end else begin
            if (state_q == ST_Q2 && q_en_q) begin
                opnd_q <= mem_q[ea_q];
            end
            if (state_q == ST_Q3 && q_en_q) begin
                res_q <= dp.res;
                c_new_q <= dp.c_out;
                z_new_q <= dp.z;
                n_new_q <= dp.n;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Q4 writeback has priority over a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (commit && op_q != OP_NONE && dst_q) begin
            mem_q[ea_q] <= res_q;
        end else if (sw_wr_mem) begin
            mem_q[addr_i[`BRU_MEM_AW-1:0]] <= wr_data_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wreg_q <= 8'h00;
        end else if (commit && op_q != OP_NONE && !dst_q) begin
            wreg_q <= res_q;
        end else if (sw_wr_reg && addr_i == `BRU_REG_WREG) begin
            wreg_q <= wr_data_i[7:0];
        end
    end

    // Carry is left alone by the no-carry rotate
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            c_q <= 1'b0;
            z_q <= 1'b0;
            n_q <= 1'b0;
        end else if (commit && op_q != OP_NONE) begin
            z_q <= z_new_q;
            n_q <= n_new_q;
            if (op_q != OP_RLNC) begin
                c_q <= c_new_q;
            end
        end else if (sw_wr_reg && addr_i == `BRU_REG_STATUS) begin
            c_q <= wr_data_i[`BRU_ST_C];
            z_q <= wr_data_i[`BRU_ST_Z];
            n_q <= wr_data_i[`BRU_ST_N];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ext_q <= 1'b0;
            bank_q <= 4'h0;
            idx_q <= 12'h000;
        end else if (sw_wr_reg) begin
            if (addr_i == `BRU_REG_CTRL) begin
                ext_q <= wr_data_i[`BRU_CTRL_EXT];
            end
            if (addr_i == `BRU_REG_BANK) begin
                bank_q <= wr_data_i[3:0];
            end
            if (addr_i == `BRU_REG_INDEX) begin
                idx_q <= wr_data_i[11:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read port; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_data_q <= 16'h0000;
        end else if (rd_i) begin
            rd_data_q <= 16'h0000;
            if (addr_i[`BRU_MEM_SEL]) begin
                rd_data_q <= {8'h00, mem_q[addr_i[`BRU_MEM_AW-1:0]]};
            end else begin
                case (addr_i)
                    `BRU_REG_CTRL: rd_data_q <= {15'h0000, ext_q};
                    `BRU_REG_INSTR: rd_data_q <= instr_q;
                    `BRU_REG_WREG: rd_data_q <= {8'h00, wreg_q};
                    `BRU_REG_STATUS: rd_data_q <= {13'h0000, n_q, z_q, c_q};
                    `BRU_REG_BANK: rd_data_q <= {12'h000, bank_q};
                    `BRU_REG_INDEX: rd_data_q <= {4'h0, idx_q};
                    `BRU_REG_STATE: rd_data_q <= {15'h0000, busy_q};
                    default: rd_data_q <= 16'h0000;
                endcase
            end
        end
    end

    assign rd_data_o = rd_data_q;
    assign busy_o = busy_q;

    ////////////////////////////////////////////////////////////////
    a_rlnc_result: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_Q4 && op_q == OP_RLNC) |-> res_q == {opnd_q[6:0], opnd_q[7]})
        else $error("left rotate result wrong");
    a_rlnc_carry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (commit && op_q == OP_RLNC) |=> c_q == $past(c_q))
        else $error("carry changed by no-carry rotate");
    a_rotate_right_via_carry_op_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (commit && op_q == OP_ROTATE_RIGHT_VIA_CARRY_OP) |=> c_q == $past(opnd_q[0]) && res_q[6:0] == opnd_q[7:1] && res_q[7] == $past(c_q))
        else $error("right rotate through carry wrong");
    a_dest_wreg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (commit && op_q != OP_NONE && !dst_q) |=> wreg_q == $past(res_q))
        else $error("working register not written");
    a_bank_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_Q1 && q_en_q && instr_q[`BRU_A_BIT]) |=> ea_q == {bank_q, instr_q[7:0]})
        else $error("bank register not used");
    a_index_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_Q1 && q_en_q && !instr_q[`BRU_A_BIT] && ext_q && instr_q[7:0] <= `BRU_ACC_SPLIT)
        |=> ea_q == idx_q + {4'h0, instr_q[7:0]})
        else $error("indexed offset address wrong");
    a_rotate_left_via_carry_op_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_Q3 && q_en_q && op_q == OP_ROTATE_LEFT_VIA_CARRY_OP) |=> res_q == {opnd_q[6:0], c_q} && c_new_q == opnd_q[7])
        else $error("left rotate through carry wrong");
    a_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_Q1 && $past(state_q) == ST_IDLE) |-> ##[5:7] (state_q == ST_Q4 && q_en_q) ##1 !busy_q)
        else $error("instruction cycle length wrong");
    a_flags_nz: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (commit && op_q != OP_NONE) |=> z_q == ($past(res_q) == 8'h00) && n_q == $past(res_q[7]))
        else $error("negative or zero flag wrong");
endmodule : bru_top
`default_nettype wire

// ### test/bru_top_bench.sv
// Self-checking bench for the byte rotate instruction unit
`include "bru_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module bru_top_bench
    import bru_pkg::*;
;
    typedef struct packed {
        logic ext;
        logic [3:0] bank;
        logic [11:0] idx;
        logic cin;
        logic [11:0] maddr;
        logic [7:0] val;
        logic [15:0] instr;
        logic [7:0] ew;
        logic [7:0] em;
        logic [2:0] est;
    } bru_row_type;
    // Status expectation is {N, Z, C}; W starts each row at A5
    localparam bru_row_type ROWS [9] = '{
        '{1'h0, 4'h0, 12'h000, 1'h1, 12'h010, 8'hAB, 16'h4610, 8'hA5, 8'h57, 3'h1},
        '{1'h0, 4'h0, 12'h000, 1'h0, 12'h020, 8'hE6, 16'h3020, 8'h73, 8'hE6, 3'h0},
        '{1'h0, 4'h0, 12'h000, 1'h0, 12'h030, 8'hE6, 16'h3430, 8'hCC, 8'hE6, 3'h5},
        '{1'h0, 4'h3, 12'h000, 1'h0, 12'h3FF, 8'h80, 16'h47FF, 8'hA5, 8'h01, 3'h0},
        '{1'h0, 4'h0, 12'h000, 1'h0, 12'hF60, 8'h01, 16'h3260, 8'hA5, 8'h00, 3'h3},
        '{1'h1, 4'h0, 12'h200, 1'h1, 12'h25F, 8'h01, 16'h365F, 8'hA5, 8'h03, 3'h0},
        '{1'h1, 4'h0, 12'h200, 1'h1, 12'hF60, 8'h81, 16'h3060, 8'hC0, 8'h81, 3'h5},
        '{1'h1, 4'h2, 12'h000, 1'h1, 12'h210, 8'h00, 16'h4510, 8'h00, 8'h00, 3'h3},
        '{1'h0, 4'h0, 12'h000, 1'h1, 12'h010, 8'h5A, 16'h0010, 8'hA5, 8'h5A, 3'h1}
    };
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [`BRU_AW-1:0] addr_i = 13'h0000;
    logic [15:0] wr_data_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rd_data_o;
    logic busy_o;
    int miscompares = 0;
    int compares = 0;
    logic [15:0] d;

    bru_top i_bru_top (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .addr_i(addr_i),
        .wr_data_i(wr_data_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rd_data_o(rd_data_o),
        .busy_o(busy_o)
    );

    always #12.5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic wr(input logic [12:0] a, input logic [15:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Data is registered at the strobe edge and holds until the next read strobe
    task automatic rd(input logic [12:0] a, output logic [15:0] v);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rd_data_o;
    endtask : rd

    // Gone counts the edges since the instruction write that passed before the call
    task automatic wait_idle(input int gone);
        int n;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_i);
            #1;
            if (busy_o === 1'b0) break;
        end
        if (busy_o !== 1'b0) begin
            miscompares++;
            $display("MISMATCH busy_timeout expected 0 seen %b", busy_o);
            conclude();
        end
        // Up to two edges to reach the first quarter pulse, then four quarters
        `CHK("cycle_count", 1'b1, (n + gone >= 4 * `BRU_QDIV + 1 && n + gone <= 4 * `BRU_QDIV + 2))
    endtask : wait_idle

    task automatic exec(input logic [15:0] instr);
        wr(`BRU_REG_INSTR, instr);
        #1;
        `CHK("busy_rise", 1'b1, busy_o)
        wait_idle(1);
    endtask : exec

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Offsets 0 to 6 reset to zero; offset 7 is unmapped and reads zero
        for (int k = 0; k < 8; k++) begin
            rd(13'(k), d);
            `CHK("reset_reg", 16'h0000, d)
        end
        `CHK("reset_busy", 1'b0, busy_o)
        wr(13'h0007, 16'hFFFF);
        rd(13'h0007, d);
        `CHK("unmapped", 16'h0000, d)

        foreach (ROWS[i]) begin
            wr(`BRU_REG_CTRL, {15'h0000, ROWS[i].ext});
            wr(`BRU_REG_BANK, {12'h000, ROWS[i].bank});
            wr(`BRU_REG_INDEX, {4'h0, ROWS[i].idx});
            wr(`BRU_REG_WREG, 16'h00A5);
            wr(`BRU_REG_STATUS, {15'h0000, ROWS[i].cin});
            wr({1'b1, ROWS[i].maddr}, {8'h00, ROWS[i].val});
            exec(ROWS[i].instr);
            rd(`BRU_REG_WREG, d);
            `CHK("w_reg", ROWS[i].ew, d[7:0])
            rd({1'b1, ROWS[i].maddr}, d);
            `CHK("file_byte", ROWS[i].em, d[7:0])
            rd(`BRU_REG_STATUS, d);
            `CHK("status", ROWS[i].est, d[2:0])
        end

        // A second instruction written while busy must be dropped
        wr(`BRU_REG_CTRL, 16'h0000);
        wr(13'h1011, 16'h0001);
        wr(`BRU_REG_INSTR, 16'h4611);
        wr(`BRU_REG_INSTR, 16'h4611);
        wait_idle(3);
        rd(13'h1011, d);
        `CHK("busy_refuse", 8'h02, d[7:0])
        rd(`BRU_REG_STATE, d);
        `CHK("state_idle", 1'b0, d[`BRU_STATE_BUSY])

        // Reset in mid-instruction abandons it and clears W
        wr(`BRU_REG_WREG, 16'h0033);
        // Left rotate into W, so a surviving instruction would show as 04
        wr(`BRU_REG_INSTR, 16'h4411);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        `CHK("reset_busy_mid", 1'b0, busy_o)
        rd(`BRU_REG_WREG, d);
        `CHK("reset_w_mid", 16'h0000, d)
        repeat (14) @(posedge clk_i);
        rd(`BRU_REG_WREG, d);
        `CHK("no_late_commit", 16'h0000, d)
        conclude();
    end
endmodule : bru_top_bench
`default_nettype wire
